// ===== hw/uab_regs.svh
// ---------------------------------------------------------------
// register map, field positions and counts of the autobaud uart
// ---------------------------------------------------------------
// definitions only; included by both ends, the checks and the bench
`ifndef UAB_REGS_SVH
`define UAB_REGS_SVH

// register offsets on the plain software port
`define UAB_OFF_CONTROL      8'h00
`define UAB_OFF_DIVISOR_LOW  8'h04
`define UAB_OFF_DIVISOR_HIGH 8'h08
`define UAB_OFF_TX_DATA      8'h0c
`define UAB_OFF_RX_DATA      8'h10

// control register fields
`define UAB_BIT_AUTOBAUD_ENABLE   0
`define UAB_BIT_WAKE_ENABLE       1
`define UAB_BIT_DIVISOR_16BIT     2
`define UAB_BIT_HIGH_SPEED        3
`define UAB_BIT_SEND_BREAK        4
`define UAB_BIT_TRANSMIT_ENABLE   5
`define UAB_BIT_AUTOBAUD_OVERFLOW 6
`define UAB_BIT_RECEIVER_IDLE     7
`define UAB_BIT_TX_SHIFT_EMPTY    8
`define UAB_BIT_RX_IRQ_FLAG       9
`define UAB_BIT_TX_BUF_EMPTY      10
`define UAB_BIT_SYNC_MODE         11

// autobaud counter tick masks, one less than the period in oscillator cycles, per {16bit, high speed}
`define UAB_ABD_PERIOD_00 9'd511
`define UAB_ABD_PERIOD_01 9'd127
`define UAB_ABD_PERIOD_10 9'd127
`define UAB_ABD_PERIOD_11 9'd31
`define UAB_ABD_TO_BASE   3

// frame shapes
`define UAB_AB_RISES      3'd4
`define UAB_NORMAL_BITS   4'd10
`define UAB_BREAK_BITS    4'd14
`define UAB_HOST_ZEROS    5'd13
`define UAB_SYNC_BYTE     8'h55
`define UAB_DIVISOR_START 16'h0001

`endif

// ===== hw/uab_pkg.sv
// ---------------------------------------------------------------
// types shared by both ends of the autobaud uart
// ---------------------------------------------------------------
// holds only types; numbers live in uab_regs.svh
package uab_pkg;

    typedef enum logic [1:0] {
        AB_IDLE,
        AB_WAIT_START,
        AB_WAIT_RISE,
        AB_COUNT
    } uab_ab_state_type;

    typedef struct packed {
        logic             rx_meta;
        logic             rx_sync;
        logic             rx_prev;
        logic [8:0]       pre;
        uab_ab_state_type ab;
        logic [2:0]       rises;
        logic [15:0]      divisor;
        logic             autobaud_enable;
        logic             wake_on_break_enable;
        logic             mode16;
        logic             high_speed;
        logic             send_break_request;
        logic             transmit_enable;
        logic             sync_mode;
        logic             ovf;
        logic             rif;
        logic [7:0]       txbuf;
        logic             txbuf_full;
        logic             tx_busy;
        logic             tx_break;
        logic [13:0]      shreg;
        logic [3:0]       bitcnt;
        logic             tx_line;
        logic [15:0]      rdata;
    } uab_dev_state_type;

    typedef struct packed {
        logic        busy;
        logic [15:0] shreg;
        logic [4:0]  bitcnt;
        logic        line;
    } uab_host_state_type;

endpackage : uab_pkg

// ===== hw/uab_link_if.sv
// ---------------------------------------------------------------
// serial link between the uart and the remote node
// ---------------------------------------------------------------
// both lines idle high; each has one driver
`timescale 1ns/1ns
interface uab_link_if;
    logic rx_line;
    logic tx_line;

    modport device (
        input  rx_line,
        output tx_line
    );
    modport host (
        output rx_line,
        input  tx_line
    );
endinterface : uab_link_if

// ===== hw/uab_tick_div.sv
// ---------------------------------------------------------------
// enabled counter giving one tick every limit+1 enabled cycles
// ---------------------------------------------------------------
// assumes clk_in at 250 MHz; clear restarts the period
`timescale 1ns/1ns
module uab_tick_div #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         reset_n_in,
    // control
    input  wire logic         clear_in,
    input  wire logic         enable_in,
    input  wire logic [W-1:0] limit_in,
    // tick
    output logic              tick_out
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    assign tick_out = enable_in && !clear_in && (cnt >= limit_in);

    always_comb begin
        next_cnt = cnt;
        if (clear_in) begin
            next_cnt = '0;
        end else if (tick_out) begin
            next_cnt = '0;
        end else if (enable_in) begin
            next_cnt = cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule : uab_tick_div

// ===== hw/uab_device.sv
// ---------------------------------------------------------------
// uart autobaud, wake on break and break transmit end
// ---------------------------------------------------------------
// software port: one-cycle strobes, read data one cycle later
// link: rx_line from the remote node, tx_line towards it
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "uab_regs.svh"
module uab_device
    import uab_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    // software register port
    input  wire logic [7:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [15:0]      rdata_out,
    // serial link
    uab_link_if.device       link
);
    uab_dev_state_type s;
    uab_dev_state_type next_s;

    logic        rise;
    logic        fall;
    logic        abd_tick;
    logic        base_tick;
    logic        bit_tick;
    logic        tx_load;
    logic [8:0]  abd_mask;
    logic [15:0] bit_limit;

    // ---------------------------------------------------------------
    // rates
    // ---------------------------------------------------------------
    function automatic logic [8:0] abd_period(input logic m16, input logic hs);
        unique case ({m16, hs})
            2'b00:   abd_period = `UAB_ABD_PERIOD_00;
            2'b01:   abd_period = `UAB_ABD_PERIOD_01;
            2'b10:   abd_period = `UAB_ABD_PERIOD_10;
            2'b11:   abd_period = `UAB_ABD_PERIOD_11;
            default: abd_period = `UAB_ABD_PERIOD_00;
        endcase
    endfunction : abd_period

    function automatic logic tick_at(input logic [8:0] pre, input logic [8:0] mask);
        tick_at = (pre & mask) == mask;
    endfunction : tick_at

    assign abd_mask  = abd_period(s.mode16, s.high_speed);
    assign abd_tick  = tick_at(s.pre, abd_mask);
    assign base_tick = tick_at(s.pre, abd_mask >> `UAB_ABD_TO_BASE);
    assign rise      = s.rx_sync && !s.rx_prev;
    assign fall      = !s.rx_sync && s.rx_prev;
    // 8-bit divisor mode ignores the high byte outside autobaud
    assign bit_limit = s.mode16 ? s.divisor : {8'h00, s.divisor[7:0]};
    assign tx_load   = !s.tx_busy && s.txbuf_full && s.transmit_enable;

    uab_tick_div #(
        .W(16)
    ) u_bit_div (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .clear_in   (tx_load),
        .enable_in  (base_tick),
        .limit_in   (bit_limit),
        .tick_out   (bit_tick)
    );

    assign link.tx_line = s.tx_line;
    assign rdata_out    = s.rdata;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        next_s         = s;
        next_s.rx_meta = link.rx_line;
        next_s.rx_sync = s.rx_meta;
        next_s.rx_prev = s.rx_sync;
        next_s.pre     = s.pre + 9'd1;
        next_s.rdata   = 16'h0000;

        // software writes first, so hardware events below win
        if (wr_in) begin
            unique case (addr_in)
                `UAB_OFF_CONTROL: begin
                    next_s.autobaud_enable      = wdata_in[`UAB_BIT_AUTOBAUD_ENABLE];
                    next_s.wake_on_break_enable        = wdata_in[`UAB_BIT_WAKE_ENABLE];
                    next_s.mode16     = wdata_in[`UAB_BIT_DIVISOR_16BIT];
                    next_s.high_speed = wdata_in[`UAB_BIT_HIGH_SPEED];
                    next_s.send_break_request      = wdata_in[`UAB_BIT_SEND_BREAK];
                    next_s.transmit_enable       = wdata_in[`UAB_BIT_TRANSMIT_ENABLE];
                    next_s.sync_mode  = wdata_in[`UAB_BIT_SYNC_MODE];
                    if (!wdata_in[`UAB_BIT_AUTOBAUD_OVERFLOW] && !s.autobaud_enable) begin
                        next_s.ovf = 1'b0;
                    end
                end
                `UAB_OFF_DIVISOR_LOW: begin
                    if (s.ab == AB_IDLE) begin
                        next_s.divisor[7:0] = wdata_in[7:0];
                    end
                end
                `UAB_OFF_DIVISOR_HIGH: begin
                    if (s.ab == AB_IDLE) begin
                        next_s.divisor[15:8] = wdata_in[7:0];
                    end
                end
                default: begin
                end
            endcase
        end

        if (rd_in) begin
            unique case (addr_in)
                `UAB_OFF_CONTROL: begin
                    next_s.rdata[`UAB_BIT_AUTOBAUD_ENABLE]   = s.autobaud_enable;
                    next_s.rdata[`UAB_BIT_WAKE_ENABLE]       = s.wake_on_break_enable;
                    next_s.rdata[`UAB_BIT_DIVISOR_16BIT]     = s.mode16;
                    next_s.rdata[`UAB_BIT_HIGH_SPEED]        = s.high_speed;
                    next_s.rdata[`UAB_BIT_SEND_BREAK]        = s.send_break_request;
                    next_s.rdata[`UAB_BIT_TRANSMIT_ENABLE]   = s.transmit_enable;
                    next_s.rdata[`UAB_BIT_AUTOBAUD_OVERFLOW] = s.ovf;
                    next_s.rdata[`UAB_BIT_RECEIVER_IDLE]     = (s.ab == AB_IDLE) && !s.wake_on_break_enable;
                    next_s.rdata[`UAB_BIT_TX_SHIFT_EMPTY]    = !s.tx_busy;
                    next_s.rdata[`UAB_BIT_RX_IRQ_FLAG]       = s.rif;
                    next_s.rdata[`UAB_BIT_TX_BUF_EMPTY]      = !s.txbuf_full;
                    next_s.rdata[`UAB_BIT_SYNC_MODE]         = s.sync_mode;
                end
                `UAB_OFF_DIVISOR_LOW:  next_s.rdata = {8'h00, s.divisor[7:0]};
                `UAB_OFF_DIVISOR_HIGH: next_s.rdata = {8'h00, s.divisor[15:8]};
                // no normal reception here, so received data is always zero
                `UAB_OFF_RX_DATA:      next_s.rif   = 1'b0;
                default: begin
                end
            endcase
        end

        // ---------------------------------------------------------------
        // autobaud measurement; the receiver idle bit reads 0 outside AB_IDLE
        // ---------------------------------------------------------------
        unique case (s.ab)
            AB_IDLE: begin
                // a pending wake waits for the break to end first
                if (s.autobaud_enable && !s.wake_on_break_enable) begin
                    next_s.ab = AB_WAIT_START;
                end
            end
            AB_WAIT_START: begin
                if (!s.autobaud_enable) begin
                    next_s.ab = AB_IDLE;
                end else if (fall) begin
                    next_s.ab = AB_WAIT_RISE;
                end
            end
            AB_WAIT_RISE: begin
                if (!s.autobaud_enable) begin
                    next_s.ab = AB_IDLE;
                end else if (rise) begin
                    next_s.ab      = AB_COUNT;
                    next_s.divisor = `UAB_DIVISOR_START;
                    next_s.rises   = 3'd0;
                end
            end
            AB_COUNT: begin
                if (!s.autobaud_enable) begin
                    next_s.ab = AB_IDLE;
                end else begin
                    if (abd_tick) begin
                        next_s.divisor = s.divisor + 16'h0001;
                        if (&s.divisor) begin
                            next_s.ovf = 1'b1;
                        end
                    end
                    if (rise) begin
                        next_s.rises = s.rises + 3'd1;
                        if (s.rises == `UAB_AB_RISES - 3'd1) begin
                            next_s.ab    = AB_IDLE;
                            next_s.autobaud_enable = 1'b0;
                            next_s.rif   = 1'b1;
                        end
                    end
                end
            end
        endcase

        // ---------------------------------------------------------------
        // wake on break
        // ---------------------------------------------------------------
        if (s.wake_on_break_enable && !s.sync_mode) begin
            if (fall) begin
                next_s.rif = 1'b1;
            end
            if (rise) begin
                next_s.wake_on_break_enable = 1'b0;
            end
        end

        // ---------------------------------------------------------------
        // transmit: buffer, shifter, break
        // ---------------------------------------------------------------
        if (tx_load) begin
            next_s.tx_busy    = 1'b1;
            next_s.txbuf_full = 1'b0;
            next_s.tx_break   = s.send_break_request;
            if (s.send_break_request) begin
                next_s.shreg  = {1'b1, 13'h0000};
                next_s.bitcnt = `UAB_BREAK_BITS;
            end else begin
                next_s.shreg  = {5'b11111, s.txbuf, 1'b0};
                next_s.bitcnt = `UAB_NORMAL_BITS;
            end
        end else if (s.tx_busy && bit_tick) begin
            next_s.shreg  = {1'b1, s.shreg[13:1]};
            next_s.bitcnt = s.bitcnt - 4'd1;
            if (s.bitcnt == 4'd1) begin
                next_s.tx_busy = 1'b0;
                if (s.tx_break) begin
                    next_s.send_break_request = 1'b0;
                end
            end
        end
        // a byte written behind the break waits in the buffer
        if (wr_in && addr_in == `UAB_OFF_TX_DATA && s.transmit_enable && (!s.txbuf_full || tx_load)) begin
            next_s.txbuf      = wdata_in[7:0];
            next_s.txbuf_full = 1'b1;
        end
        next_s.tx_line = next_s.tx_busy ? next_s.shreg[0] : 1'b1;
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            s         <= '0;
            s.rx_meta <= 1'b1;
            s.rx_sync <= 1'b1;
            s.rx_prev <= 1'b1;
            s.ab      <= AB_IDLE;
            s.shreg   <= 14'h3fff;
            s.tx_line <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
endmodule : uab_device

// ===== hw/uab_host.sv
// ---------------------------------------------------------------
// remote node: sends wake breaks and bytes on the rx line
// ---------------------------------------------------------------
// one request at a time; requests while busy are ignored
`timescale 1ns/1ns
`include "uab_regs.svh"
module uab_host
    import uab_pkg::*;
#(
    parameter logic [15:0] BIT_CYCLES = 16'd64
) (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    // requests
    input  wire logic       send_break_in,
    input  wire logic       send_byte_in,
    input  wire logic [7:0] byte_in,
    output logic            busy_out,
    // serial link
    uab_link_if.host        link
);
    uab_host_state_type s;
    uab_host_state_type next_s;
    logic               start;
    logic               bit_tick;

    assign start        = !s.busy && (send_break_in || send_byte_in);
    assign busy_out     = s.busy;
    assign link.rx_line = s.line;

    uab_tick_div #(
        .W(16)
    ) u_bit_div (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .clear_in   (start),
        .enable_in  (1'b1),
        .limit_in   (BIT_CYCLES - 16'd1),
        .tick_out   (bit_tick)
    );

    always_comb begin
        next_s = s;
        if (start) begin
            next_s.busy = 1'b1;
            // break wins when both are asked at once
            if (send_break_in) begin
                next_s.shreg  = {3'b111, 13'h0000};
                next_s.bitcnt = `UAB_HOST_ZEROS + 5'd1;
            end else begin
                next_s.shreg  = {7'h7f, byte_in, 1'b0};
                next_s.bitcnt = {1'b0, `UAB_NORMAL_BITS};
            end
        end else if (s.busy && bit_tick) begin
            next_s.shreg  = {1'b1, s.shreg[15:1]};
            next_s.bitcnt = s.bitcnt - 5'd1;
            if (s.bitcnt == 5'd1) begin
                next_s.busy = 1'b0;
            end
        end
        next_s.line = next_s.busy ? next_s.shreg[0] : 1'b1;
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            s       <= '0;
            s.shreg <= 16'hffff;
            s.line  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
endmodule : uab_host

// ===== sim/uab_link_assertions.sv
// ---------------------------------------------------------------
// link and register port checks for the autobaud uart
// ---------------------------------------------------------------
// sees the register port, the node requests and both link lines
`timescale 1ns/1ns
`include "uab_regs.svh"
module uab_link_assertions #(
    parameter int BIT_CYCLES = 64
) (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    // register port
    input  wire logic [7:0]  addr_in,
    input  wire logic        rd_in,
    input  wire logic [15:0] rdata_out,
    // remote node
    input  wire logic        send_break_in,
    input  wire logic        send_byte_in,
    input  wire logic        busy_out,
    // link
    input  wire logic        rx_line,
    input  wire logic        tx_line
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    localparam int MAX_LOW = 13 * BIT_CYCLES;

    logic [15:0] rx_low;
    logic [3:0]  rx_quiet;
    logic        rx_prev;

    // saturating counters, so a stuck line cannot wrap back into range
    always_ff @(posedge clk_in) begin
        rx_prev <= rx_line;
        if (!reset_n_in || rx_line) begin
            rx_low <= 16'h0;
        end else if (rx_low != 16'hffff) begin
            rx_low <= rx_low + 16'h1;
        end
        if (!reset_n_in || rx_line != rx_prev) begin
            rx_quiet <= 4'h0;
        end else if (rx_quiet != 4'hf) begin
            rx_quiet <= rx_quiet + 4'h1;
        end
    end

    rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 16'h0)
        else $error("read data outside the answer cycle");
    unmapped_read_a: assert property (rd_in && !(addr_in inside {`UAB_OFF_CONTROL,
        `UAB_OFF_DIVISOR_LOW, `UAB_OFF_DIVISOR_HIGH, `UAB_OFF_TX_DATA, `UAB_OFF_RX_DATA})
        |=> rdata_out == 16'h0)
        else $error("unmapped read returned data");
    divisor_high_a: assert property (rd_in && addr_in == `UAB_OFF_DIVISOR_HIGH
        |=> rdata_out[15:8] == 8'h0)
        else $error("divisor high byte has stray bits");
    ctrl_spare_a: assert property (rd_in && addr_in == `UAB_OFF_CONTROL
        |=> rdata_out[15:12] == 4'h0)
        else $error("spare control bits set");
    rx_data_zero_a: assert property (rd_in && addr_in == `UAB_OFF_RX_DATA
        |=> rdata_out == 16'h0)
        else $error("receive data not zero");
    flag_clear_a: assert property (rd_in && addr_in == `UAB_OFF_RX_DATA && rx_quiet == 4'hf
        ##2 rd_in && addr_in == `UAB_OFF_CONTROL |=> !rdata_out[`UAB_BIT_RX_IRQ_FLAG])
        else $error("receive flag survived a data read");
    frame_active_a: assert property (rd_in && addr_in == `UAB_OFF_CONTROL && !tx_line
        |=> !rdata_out[`UAB_BIT_TX_SHIFT_EMPTY])
        else $error("shift empty while the line is low");
    node_start_a: assert property ((send_break_in || send_byte_in) && !busy_out
        |-> ##[1:2] (!rx_line && busy_out))
        else $error("node request not started");
    break_length_a: assert property (rx_low <= 16'(MAX_LOW))
        else $error("receive line low too long");
endmodule : uab_link_assertions

// ===== sim/tb_uart_autobaud_wake_break.sv
// ---------------------------------------------------------------
// self-checking bench: uart end and remote node on one link
// ---------------------------------------------------------------
// drives the register port and node requests; watches the link
`timescale 1ns/1ns
`include "uab_regs.svh"
module tb_uart_autobaud_wake_break;
    localparam int         BIT   = 64;
    localparam int         LIMIT = 40000;
    localparam logic [7:0] A_CTL = `UAB_OFF_CONTROL;
    localparam logic [7:0] A_RX  = `UAB_OFF_RX_DATA;

    // control bits [3:2] and ticks of 8 bits of BIT cycles
    typedef struct packed {
        logic [1:0]  mode;
        logic [15:0] ticks;
    } uab_row_type;
    uab_row_type rows [4] = '{'{2'b00, 16'd1}, '{2'b01, 16'd4},
                              '{2'b10, 16'd4}, '{2'b11, 16'd16}};

    logic        clk_in;
    logic        reset_n_in;
    logic [7:0]  addr_in;
    logic [15:0] wdata_in;
    logic        wr_in;
    logic        rd_in;
    logic [15:0] rdata_out;
    logic        send_break_in;
    logic        send_byte_in;
    logic [7:0]  byte_in;
    logic        busy_out;
    logic [15:0] v;
    logic        tx_prev;
    int          tx_run;
    int          lows[$];
    int          highs[$];
    int          n_errors;
    int          comparisons;
    int          cycles;

    uab_link_if u_uab_link_if ();
    uab_device u_uab_device (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .link(u_uab_link_if.device));
    uab_host #(.BIT_CYCLES(16'(BIT))) u_uab_host (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .send_break_in(send_break_in), .send_byte_in(send_byte_in), .byte_in(byte_in),
        .busy_out(busy_out), .link(u_uab_link_if.host));
    uab_link_assertions #(.BIT_CYCLES(BIT)) u_uab_link_assertions (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .addr_in(addr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .send_break_in(send_break_in), .send_byte_in(send_byte_in), .busy_out(busy_out),
        .rx_line(u_uab_link_if.rx_line), .tx_line(u_uab_link_if.tx_line));

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    // ---------------------------------------------------------------
    // timeout and transmit run lengths
    // ---------------------------------------------------------------
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            test_done();
        end
        if (u_uab_link_if.tx_line !== tx_prev) begin
            if (tx_prev === 1'b0) lows.push_back(tx_run);
            else highs.push_back(tx_run);
            tx_run = 1;
        end else begin
            tx_run++;
        end
        tx_prev = u_uab_link_if.tx_line;
    end

    task automatic test_done();
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_in(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        comparisons++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk_in

    // tasks start and end right after a rising edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        @(posedge clk_in);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(posedge clk_in);
        d = rdata_out;
    endtask : rd

    task automatic chk_ctrl(input logic [15:0] mask, input logic [15:0] exp);
        logic [15:0] c;
        rd(A_CTL, c);
        chk(c & mask, exp);
    endtask : chk_ctrl

    task automatic rd_div(output logic [15:0] d);
        logic [15:0] lo;
        logic [15:0] hi;
        rd(`UAB_OFF_DIVISOR_LOW, lo);
        rd(`UAB_OFF_DIVISOR_HIGH, hi);
        d = {hi[7:0], lo[7:0]};
    endtask : rd_div

    task automatic node(input logic brk, input logic [7:0] b);
        send_break_in <= brk;
        send_byte_in  <= !brk;
        byte_in       <= b;
        @(posedge clk_in);
        send_break_in <= 1'b0;
        send_byte_in  <= 1'b0;
        @(posedge clk_in);
    endtask : node

    task automatic node_wait();
        for (int i = 0; i < 2000 && busy_out !== 1'b0; i++) @(posedge clk_in);
        // device sees line edges three cycles late
        repeat (6) @(posedge clk_in);
    endtask : node_wait

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        reset_n_in = 1'b0;
        addr_in = 8'h00;
        wdata_in = 16'h0000;
        wr_in = 1'b0;
        rd_in = 1'b0;
        send_break_in = 1'b0;
        send_byte_in = 1'b0;
        byte_in = 8'h00;
        tx_prev = 1'b1;
        repeat (10) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        foreach (rows[i]) begin
            wr(A_CTL, {12'h0, rows[i].mode, 2'b01});
            node(1'b0, `UAB_SYNC_BYTE);
            repeat (200) @(posedge clk_in);
            chk_ctrl(16'h0081, 16'h0001);
            node_wait();
            chk_ctrl(16'h024d, {6'h0, 1'b1, 5'h0, rows[i].mode, 2'b00});
            rd_div(v);
            chk_in(v, rows[i].ticks, rows[i].ticks + 16'h2);
            rd(A_RX, v);
            chk(v, 16'h0);
            chk_ctrl(16'h0200, 16'h0);
        end
        // wake on break, then wake with autobaud on the next byte
        chk_ctrl(16'h0080, 16'h0080);
        wr(A_CTL, 16'h0002);
        node(1'b1, 8'h00);
        repeat (100) @(posedge clk_in);
        chk_ctrl(16'h0282, 16'h0202);
        node_wait();
        chk_ctrl(16'h0202, 16'h0200);
        rd(A_RX, v);
        chk_ctrl(16'h0200, 16'h0);
        wr(A_CTL, 16'h000f);
        node(1'b1, 8'h00);
        node_wait();
        chk_ctrl(16'h0203, 16'h0201);
        rd(A_RX, v);
        node(1'b0, `UAB_SYNC_BYTE);
        node_wait();
        chk_ctrl(16'h0203, 16'h0200);
        rd_div(v);
        chk_in(v, 16'd16, 16'd18);
        rd(A_RX, v);
        wr(A_CTL, 16'h0802);
        node(1'b1, 8'h00);
        node_wait();
        chk_ctrl(16'h0200, 16'h0);
        wr(A_CTL, 16'h0002);
        node(1'b0, `UAB_SYNC_BYTE);
        node_wait();
        chk_ctrl(16'h0202, 16'h0200);
        rd(A_RX, v);
        // reset in mid-run and unmapped places
        wr(A_CTL, 16'h087e);
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk_ctrl(16'h0a7f, 16'h0);
        rd_div(v);
        chk(v, 16'h0);
        wr(8'h14, 16'hffff);
        chk_ctrl(16'h0a7f, 16'h0);
        rd(8'h14, v);
        chk(v, 16'h0);
        // break then sync byte; bit is 8 base ticks of 4 cycles
        wr(`UAB_OFF_DIVISOR_LOW, 16'h0007);
        wr(`UAB_OFF_DIVISOR_HIGH, 16'h0000);
        wr(A_CTL, 16'h003c);
        lows.delete();
        highs.delete();
        addr_in  <= `UAB_OFF_TX_DATA;
        wdata_in <= 16'h00ff;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wdata_in <= {8'h00, `UAB_SYNC_BYTE};
        @(posedge clk_in);
        wr_in <= 1'b0;
        @(posedge clk_in);
        chk_ctrl(16'h0510, 16'h0010);
        for (int i = 0; i < 1000 && highs.size() < 2; i++) @(posedge clk_in);
        chk_ctrl(16'h0510, 16'h0400);
        for (int i = 0; i < 100; i++) begin
            rd(A_CTL, v);
            if (v[`UAB_BIT_TX_SHIFT_EMPTY] === 1'b1) break;
            repeat (8) @(posedge clk_in);
        end
        chk_ctrl(16'h0100, 16'h0100);
        chk(16'(lows.size()), 16'd6);
        chk_in(16'(lows[0]), 16'd412, 16'd416);
        chk_in(16'(highs[1]), 16'd32, 16'd36);
        chk_in(16'(lows[1]), 16'd28, 16'd32);
        for (int k = 2; k < 6; k++) chk(16'(lows[k]), 16'd32);
        for (int k = 2; k < 6; k++) chk(16'(highs[k]), 16'd32);
        test_done();
    end
endmodule : tb_uart_autobaud_wake_break
